/* File: sio_defs.vh */
// Register map, field positions, reset values and timing counts of the serial port
`ifndef SIO_DEFS_VH
`define SIO_DEFS_VH
`define OFF_CTRL 12'h000
`define OFF_MODE 12'h004
`define OFF_STAT 12'h008
`define OFF_TXD 12'h00c
`define OFF_RXD 12'h010
`define OFF_MASK 12'h014
`define OFF_DMAEN 12'h018
// serial_control_register fields
`define CTRL_TXEN 0
`define CTRL_RXEN 1
`define CTRL_PAR_EN 2
`define CTRL_PAR_ODD 3
`define CTRL_STOP2 4
`define CTRL_LEN8 5
`define CTRL_CLKOUT 6
`define CTRL_ADDR_BIT 11
`define CTRL_RESET 12'h023
// mode register fields
`define MODE_OP_LO 0
`define MODE_OP_HI 1
`define MODE_CS_LO 2
`define MODE_CS_HI 3
`define MODE_RATE_LO 4
`define MODE_RATE_HI 6
`define MODE_RESET 7'h00
// status bits
`define ST_RX_DONE 0
`define ST_TX_DONE 1
`define ST_FRAME 2
`define ST_OVERRUN 3
`define ST_PARITY 4
`define ST_TX_EMPTY 5
`define ST_RX_FULL 6
// operation modes
`define OP_ASYNC 2'h0
`define OP_MULTI 2'h1
`define OP_SYNC 2'h2
// clock sources
`define CS_BAUD 2'h0
`define CS_EXT 2'h1
`define CS_TIMER 2'h2
// 16x oversampling in start-stop modes
`define OVERSAMPLE 16
// Shortest internal shift clock, in machine cycles
`define SCLK_MIN_CYC 4
`endif

/* File: serial_async_sync_port.v */
// Serial port with start-stop and clocked modes, APB slave and interrupts
`timescale 1ns/1ps
// Summary of operation
// R01: Both directions work in synchronous and start-stop modes.
// R02: Multiprocessor mode sends as master only, with the address flag set from software.
// R03: Receive interrupt on done or error, transmit interrupt on done.
// R04: Transmitter and receiver run together, each with a holding buffer and a shifter.
// R05: Synchronous mode shifts only data bits, no start, stop or parity.
// R06: The internal baud generator offers eight selectable rates.
// R07: The bit clock may come from the external clock pin or reload timer zero underflow.
// R08: Length is eight bits, seven allowed only in asynchronous normal mode.
// R09: Line data is NRZ.
// R10: Framing, overrun and parity errors are detected, parity not in multiprocessor mode.
// R11: Normal mode allows seven or eight bits, optional parity, one or two stop bits.
// R12: Multiprocessor frames carry eight data bits plus control bit 11, with no parity.
// R13: Only the first stop bit is checked on reception.
// R14: Transmit and receive events can request the intelligent I/O service instead of an interrupt.
// R15: A driven shift clock period is at least four machine cycles.
// R16: An external shift clock holds each phase at least two machine cycles.
// R17: Output changes after the falling shift clock edge, input sampled on the rising edge.
module serial_async_sync_port #(
    parameter BASE_DIV = 16'd2
)(
    input wire REF_CLK,
    input wire NRST,
    input wire CLK_EN,
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [11:0] PADDR,
    input wire [31:0] PWDATA,
    output reg [31:0] PRDATA,
    output wire PREADY,
    output wire PSLVERR,
    input wire SERIAL_IN_PIN,
    output reg SERIAL_OUT_PIN,
    input wire SHIFT_CLOCK_PIN_I,
    output reg SHIFT_CLOCK_PIN_O,
    output wire SHIFT_CLOCK_PIN_OE_N,
    input wire TIMER0_UNDERFLOW,
    output wire IRQ_RX,
    output wire IRQ_TX,
    output wire IIO_REQ_RX,
    output wire IIO_REQ_TX
);
`include "sio_defs.vh"
    reg [11:0] serial_control_register_q;
    reg [6:0] mode_q;
    reg [4:0] stat_q;
    reg [4:0] mask_q;
    reg [1:0] dmaen_q;
    reg [8:0] txbuf_q;
    reg txfull_q;
    reg [7:0] rxbuf_q;
    reg rxfull_q;
    wire wr = PSEL && PENABLE && PWRITE;
    wire rd = PSEL && PENABLE && !PWRITE;
    wire [1:0] op = mode_q[`MODE_OP_HI:`MODE_OP_LO];
    wire [1:0] csel = mode_q[`MODE_CS_HI:`MODE_CS_LO];
    wire [2:0] rate = mode_q[`MODE_RATE_HI:`MODE_RATE_LO];
    wire sync_m = (op == `OP_SYNC); // R01
    wire multi_m = (op == `OP_MULTI);
    wire len8 = serial_control_register_q[`CTRL_LEN8] || (op != `OP_ASYNC); // R08
    wire par_en = serial_control_register_q[`CTRL_PAR_EN] && (op == `OP_ASYNC); // R10 R12
    wire par_odd = serial_control_register_q[`CTRL_PAR_ODD];
    wire clk_drive = sync_m && serial_control_register_q[`CTRL_CLKOUT];
    wire mapped = (PADDR == `OFF_CTRL) || (PADDR == `OFF_MODE) || (PADDR == `OFF_STAT) ||
        (PADDR == `OFF_TXD) || (PADDR == `OFF_RXD) || (PADDR == `OFF_MASK) || (PADDR == `OFF_DMAEN);
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL && PENABLE && !mapped;
    assign SHIFT_CLOCK_PIN_OE_N = !clk_drive;

    // Baud generator: eight rates, base divider shifted by the rate code
    reg [23:0] bcnt_q;
    wire [23:0] bdiv = ({8'h00, BASE_DIV} << rate) - 24'h000001; // R06
    wire baud_tick = CLK_EN && (bcnt_q == 24'h000000);
    always @(posedge REF_CLK or negedge NRST)
        if (!NRST)
            bcnt_q <= 24'h000000;
        else if (CLK_EN)
            bcnt_q <= (bcnt_q == 24'h000000) ? bdiv : bcnt_q - 24'h000001;

    // External clock and timer edges
    reg sck_in_q;
    reg tmr_q;
    always @(posedge REF_CLK or negedge NRST)
        if (!NRST)
        begin
            sck_in_q <= 1'b1;
            tmr_q <= 1'b0;
        end
        else if (CLK_EN)
        begin
            sck_in_q <= SHIFT_CLOCK_PIN_I;
            tmr_q <= TIMER0_UNDERFLOW;
        end
    wire ext_rise = CLK_EN && SHIFT_CLOCK_PIN_I && !sck_in_q; // R16
    wire ext_fall = CLK_EN && !SHIFT_CLOCK_PIN_I && sck_in_q;
    wire tmr_tick = CLK_EN && TIMER0_UNDERFLOW && !tmr_q;
    reg src_tick;
    always @*
    begin
        case (csel) // R07
            `CS_BAUD: src_tick = baud_tick;
            `CS_EXT: src_tick = ext_rise;
            `CS_TIMER: src_tick = tmr_tick;
            default: src_tick = baud_tick;
        endcase
    end

    // Synchronous shift clock: two ticks per period, each at least two cycles apart
    reg busy_sync_q;
    wire busy_sync = busy_sync_q || (sync_m && txfull_q);
    localparam HALF_RELOAD = `SCLK_MIN_CYC / 2 - 1;
    reg [1:0] half_q;
    reg sck_ph_q;
    wire half_ok = (half_q == 2'h0);
    wire int_fall = clk_drive && src_tick && half_ok && sck_ph_q;
    wire int_rise = clk_drive && src_tick && half_ok && !sck_ph_q;
    always @(posedge REF_CLK or negedge NRST)
        if (!NRST)
        begin
            half_q <= 2'h0;
            sck_ph_q <= 1'b1;
            SHIFT_CLOCK_PIN_O <= 1'b1;
        end
        else if (CLK_EN)
        begin
            if (!clk_drive || !busy_sync)
            begin
                sck_ph_q <= 1'b1;
                SHIFT_CLOCK_PIN_O <= 1'b1;
            end
            else if (src_tick && half_ok)
            begin
                sck_ph_q <= !sck_ph_q;
                SHIFT_CLOCK_PIN_O <= !sck_ph_q;
                half_q <= HALF_RELOAD[1:0]; // R15
            end
            else if (!half_ok)
                half_q <= half_q - 2'h1;
        end
    wire s_fall = clk_drive ? int_fall : ext_fall; // R17
    wire s_rise = clk_drive ? int_rise : ext_rise; // R17

    // Transmitter
    localparam T_IDLE = 2'h0;
    localparam T_SHIFT = 2'h1;
    reg [1:0] tst_q;
    reg [11:0] tsh_q;
    reg [3:0] tbits_q;
    reg [3:0] tos_q;
    reg tx_done_p;
    // Sync frame ends on its last rising edge, no trailing clock pulse
    wire tx_step = sync_m ? ((tst_q == T_SHIFT && tbits_q == 4'h0) ? s_rise : s_fall) :
        (src_tick && tos_q == 4'h0);
    wire [7:0] tdat = len8 ? txbuf_q[7:0] : {1'b0, txbuf_q[6:0]};
    wire tpar = (^tdat) ^ par_odd;
    reg [11:0] tframe;
    reg [3:0] tlen;
    always @*
    begin
        tframe = 12'hfff;
        tlen = 4'h0;
        if (sync_m)
        begin
            tframe = {4'hf, txbuf_q[7:0]}; // R05
            tlen = 4'h8;
        end
        else if (multi_m)
        begin
            tframe = {2'h3, serial_control_register_q[`CTRL_ADDR_BIT], txbuf_q[7:0], 1'b0}; // R02 R12
            tlen = serial_control_register_q[`CTRL_STOP2] ? 4'hc : 4'hb;
        end
        else
        begin
            tframe = len8 ? (par_en ? {1'b1, 1'b1, tpar, tdat, 1'b0} : {2'h3, 1'b1, tdat, 1'b0}) :
                (par_en ? {2'h3, 1'b1, tpar, tdat[6:0], 1'b0} : {3'h7, 1'b1, tdat[6:0], 1'b0}); // R11
            tlen = 4'h9 + (len8 ? 4'h1 : 4'h0) + (par_en ? 4'h1 : 4'h0) +
                (serial_control_register_q[`CTRL_STOP2] ? 4'h1 : 4'h0) - 4'h1 + 4'h1;
        end
    end
    always @(posedge REF_CLK or negedge NRST)
        if (!NRST)
        begin
            tst_q <= T_IDLE;
            tsh_q <= 12'hfff;
            tbits_q <= 4'h0;
            tos_q <= 4'h0;
            tx_done_p <= 1'b0;
            busy_sync_q <= 1'b0;
            SERIAL_OUT_PIN <= 1'b1;
        end
        else if (CLK_EN)
        begin
            tx_done_p <= 1'b0;
            if (!sync_m && src_tick)
                tos_q <= tos_q + 4'h1;
            case (tst_q)
                T_IDLE:
                    if (txfull_q && serial_control_register_q[`CTRL_TXEN] && tx_step) // R04
                    begin
                        tsh_q <= {1'b1, tframe[11:1]};
                        SERIAL_OUT_PIN <= tframe[0]; // R09
                        tbits_q <= tlen - 4'h1;
                        busy_sync_q <= sync_m;
                        tst_q <= T_SHIFT;
                    end
                    else if (!sync_m)
                        SERIAL_OUT_PIN <= 1'b1;
                T_SHIFT:
                    if (tx_step)
                    begin
                        if (tbits_q == 4'h0)
                        begin
                            // Sync line holds the last bit; it only moves after a falling edge
                            if (!sync_m)
                                SERIAL_OUT_PIN <= 1'b1;
                            busy_sync_q <= 1'b0;
                            tx_done_p <= 1'b1;
                            tst_q <= T_IDLE;
                        end
                        else
                        begin
                            SERIAL_OUT_PIN <= tsh_q[0];
                            tsh_q <= {1'b1, tsh_q[11:1]};
                            tbits_q <= tbits_q - 4'h1;
                        end
                    end
                default: tst_q <= T_IDLE;
            endcase
        end
    wire tx_load = CLK_EN && tst_q == T_IDLE && txfull_q && serial_control_register_q[`CTRL_TXEN] && tx_step;

    // Receiver
    localparam R_IDLE = 2'h0;
    localparam R_START = 2'h1;
    localparam R_DATA = 2'h2;
    localparam R_STOP = 2'h3;
    reg [1:0] rst_q;
    reg [3:0] ros_q;
    reg [3:0] rbits_q;
    reg [9:0] rsh_q;
    reg rx_ev_p;
    reg [2:0] rx_err_p;
    wire [3:0] rlen = sync_m ? 4'h8 : (multi_m ? 4'h9 : ((len8 ? 4'h8 : 4'h7) + (par_en ? 4'h1 : 4'h0)));
    wire rx_mid = src_tick && ros_q == 4'h7;
    wire [9:0] ralign = rsh_q >> (4'ha - rlen);
    wire rpar_bad = par_en && ((^ralign[8:0]) != par_odd); // R10
    always @(posedge REF_CLK or negedge NRST)
        if (!NRST)
        begin
            rst_q <= R_IDLE;
            ros_q <= 4'h0;
            rbits_q <= 4'h0;
            rsh_q <= 10'h000;
            rx_ev_p <= 1'b0;
            rx_err_p <= 3'h0;
        end
        else if (CLK_EN)
        begin
            rx_ev_p <= 1'b0;
            rx_err_p <= 3'h0;
            if (src_tick)
                ros_q <= ros_q + 4'h1;
            if (!serial_control_register_q[`CTRL_RXEN])
                rst_q <= R_IDLE;
            else if (sync_m)
            begin
                if (s_rise) // R05 R17
                begin
                    rsh_q <= {SERIAL_IN_PIN, rsh_q[9:1]};
                    if (rbits_q == 4'h7)
                    begin
                        rbits_q <= 4'h0;
                        rx_ev_p <= 1'b1;
                    end
                    else
                        rbits_q <= rbits_q + 4'h1;
                end
            end
            else
            case (rst_q)
                R_IDLE:
                    if (src_tick && !SERIAL_IN_PIN)
                    begin
                        ros_q <= 4'h1;
                        rst_q <= R_START;
                    end
                R_START:
                    if (rx_mid)
                        rst_q <= SERIAL_IN_PIN ? R_IDLE : R_DATA;
                R_DATA:
                    if (rx_mid)
                    begin
                        rsh_q <= {SERIAL_IN_PIN, rsh_q[9:1]};
                        if (rbits_q == rlen - 4'h1)
                        begin
                            rbits_q <= 4'h0;
                            rst_q <= R_STOP;
                        end
                        else
                            rbits_q <= rbits_q + 4'h1;
                    end
                R_STOP:
                    if (rx_mid) // R13
                    begin
                        rx_ev_p <= 1'b1;
                        rx_err_p <= {rpar_bad, 1'b0, !SERIAL_IN_PIN};
                        rst_q <= R_IDLE;
                    end
                default: rst_q <= R_IDLE;
            endcase
        end
    wire [7:0] rword = sync_m ? rsh_q[9:2] : (len8 ? ralign[7:0] : {1'b0, ralign[6:0]});
    wire rx_ovr = rx_ev_p && rxfull_q; // R10

    // Registers, buffers and sticky status
    wire [4:0] ev = {rx_err_p[2], rx_ovr, rx_err_p[0], tx_done_p, rx_ev_p};
    wire [4:0] clr = (wr && PADDR == `OFF_STAT) ? PWDATA[4:0] : 5'h00;
    always @(posedge REF_CLK or negedge NRST)
        if (!NRST)
        begin
            serial_control_register_q <= `CTRL_RESET;
            mode_q <= `MODE_RESET;
            stat_q <= 5'h00;
            mask_q <= 5'h00;
            dmaen_q <= 2'h0;
            txbuf_q <= 9'h000;
            txfull_q <= 1'b0;
            rxbuf_q <= 8'h00;
            rxfull_q <= 1'b0;
        end
        else if (CLK_EN)
        begin
            stat_q <= (stat_q & ~clr) | ev; // R03
            if (wr && PADDR == `OFF_CTRL)
                serial_control_register_q <= PWDATA[11:0];
            if (wr && PADDR == `OFF_MODE)
                mode_q <= PWDATA[6:0];
            if (wr && PADDR == `OFF_MASK)
                mask_q <= PWDATA[4:0];
            if (wr && PADDR == `OFF_DMAEN)
                dmaen_q <= PWDATA[1:0];
            if (wr && PADDR == `OFF_TXD)
            begin
                txbuf_q <= PWDATA[8:0];
                txfull_q <= 1'b1; // R04
            end
            else if (tx_load)
                txfull_q <= 1'b0;
            if (rx_ev_p && !rxfull_q)
            begin
                rxbuf_q <= rword;
                rxfull_q <= 1'b1; // R04
            end
            else if (rd && PADDR == `OFF_RXD)
                rxfull_q <= 1'b0;
        end
    always @*
    begin
        PRDATA = 32'h00000000;
        case (PADDR)
            `OFF_CTRL: PRDATA = {20'h00000, serial_control_register_q};
            `OFF_MODE: PRDATA = {25'h0000000, mode_q};
            `OFF_STAT: PRDATA = {25'h0000000, rxfull_q, !txfull_q, stat_q};
            `OFF_TXD: PRDATA = {23'h000000, txbuf_q};
            `OFF_RXD: PRDATA = {24'h000000, rxbuf_q};
            `OFF_MASK: PRDATA = {27'h0000000, mask_q};
            `OFF_DMAEN: PRDATA = {30'h00000000, dmaen_q};
            default: PRDATA = 32'h00000000;
        endcase
    end
    wire rx_pend = |(stat_q[4:2] & mask_q[4:2]) || (stat_q[0] && mask_q[0]);
    wire tx_pend = stat_q[1] && mask_q[1];
    assign IRQ_RX = rx_pend && !dmaen_q[0]; // R03 R14
    assign IRQ_TX = tx_pend && !dmaen_q[1]; // R03 R14
    assign IIO_REQ_RX = rx_pend && dmaen_q[0]; // R14
    assign IIO_REQ_TX = tx_pend && dmaen_q[1]; // R14
endmodule

/* File: sio_port_asserts.sv */
// Checker of bus, shift clock and interrupt relations of the serial port
`timescale 1ns/1ps
`include "sio_defs.vh"
module sio_port_checker (
    input wire REF_CLK,
    input wire NRST,
    input wire CLK_EN,
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [11:0] PADDR,
    input wire [31:0] PWDATA,
    input wire [31:0] PRDATA,
    input wire PREADY,
    input wire PSLVERR,
    input wire SERIAL_OUT_PIN,
    input wire SHIFT_CLOCK_PIN_O,
    input wire SHIFT_CLOCK_PIN_OE_N,
    input wire IRQ_RX,
    input wire IRQ_TX,
    input wire IIO_REQ_RX,
    input wire IIO_REQ_TX
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!NRST);
    wire acc = PSEL && PENABLE;
    wire unmapped = (PADDR > `OFF_DMAEN) || (PADDR[1:0] != 2'h0);
    AST_PREADY: assert property (PSEL |-> PREADY) else $error("pready low in a transfer");
    AST_UNMAPPED_ERR: assert property (acc && unmapped |-> PSLVERR && (PWRITE || PRDATA == 32'h0))
        else $error("unmapped access not refused");
    AST_MAPPED_OK: assert property (acc && !unmapped |-> !PSLVERR) else $error("mapped access refused");
    AST_SCLK_HIGH: assert property ($rose(SHIFT_CLOCK_PIN_O) && !SHIFT_CLOCK_PIN_OE_N |=> SHIFT_CLOCK_PIN_O)
        else $error("shift clock high phase too short");
    AST_SCLK_LOW: assert property ($fell(SHIFT_CLOCK_PIN_O) && !SHIFT_CLOCK_PIN_OE_N |=> !SHIFT_CLOCK_PIN_O)
        else $error("shift clock low phase too short");
    AST_TX_AFTER_FALL: assert property (!SHIFT_CLOCK_PIN_OE_N && !$past(SHIFT_CLOCK_PIN_OE_N)
        && $changed(SERIAL_OUT_PIN) |-> !SHIFT_CLOCK_PIN_O) else $error("serial out moved while clock high");
    AST_IIO_RX_EXCL: assert property (!(IRQ_RX && IIO_REQ_RX)) else $error("rx irq and service both high");
    AST_IIO_TX_EXCL: assert property (!(IRQ_TX && IIO_REQ_TX)) else $error("tx irq and service both high");
    AST_MASK_OFF: assert property (acc && PWRITE && CLK_EN && PADDR == `OFF_MASK && PWDATA[4:0] == 5'h00
        |=> !IRQ_RX && !IRQ_TX && !IIO_REQ_RX && !IIO_REQ_TX) else $error("masked event still signalled");
    cover property (IIO_REQ_RX);
    cover property ($fell(SHIFT_CLOCK_PIN_O) && !SHIFT_CLOCK_PIN_OE_N);
    cover property (acc && PSLVERR);
endmodule
bind serial_async_sync_port sio_port_checker u_chk (.REF_CLK(REF_CLK), .NRST(NRST), .CLK_EN(CLK_EN),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .SERIAL_OUT_PIN(SERIAL_OUT_PIN), .SHIFT_CLOCK_PIN_O(SHIFT_CLOCK_PIN_O),
    .SHIFT_CLOCK_PIN_OE_N(SHIFT_CLOCK_PIN_OE_N), .IRQ_RX(IRQ_RX), .IRQ_TX(IRQ_TX),
    .IIO_REQ_RX(IIO_REQ_RX), .IIO_REQ_TX(IIO_REQ_TX));

/* File: far_serial_device.sv */
// Far side model: loopback plug while the shift clock pin is an input, clocked slave when the port drives the shift clock
`timescale 1ns/1ps
module far_serial_device (
    input wire sout,
    input wire sclk,
    input wire oe_n,
    output wire sin
);
    logic [7:0] tx_byte = 8'h6b;
    logic [7:0] got = 8'h00;
    logic [3:0] idx = 4'h0;
    always @(negedge sclk)
        if (!oe_n) idx <= idx + 4'h1;
    always @(posedge oe_n)
        idx <= 4'h0;
    always @(posedge sclk)
        if (!oe_n) got <= {sout, got[7:1]};
    // Before the first falling edge the line idles high; after the eighth it holds bit 7 until the next fall or oe_n rises
    assign sin = oe_n ? sout : ((idx >= 4'h1 && idx <= 4'h8) ? tx_byte[idx - 4'h1] : 1'b1);
endmodule

/* File: tb_top.sv */
// Testbench of the serial port: register, loopback, synchronous and overrun tests
`timescale 1ns/1ps
`include "sio_defs.vh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin bad_count++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
    logic clk = 0, nrst = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rdv;
    logic [1:0] tc = 2'h0;
    wire [31:0] prdata;
    wire pready, pslverr, sin, sout, sck_o, sck_oe_n, irq_rx, irq_tx, iio_rx, iio_tx;
    wire sck_i = sck_oe_n ? tc[1] : sck_o;
    int bad_count = 0, checks_done = 0, n;
    logic [11:0] cfg_ctrl [8] = '{12'h023, 12'h003, 12'h037, 12'h02f, 12'h827, 12'h023, 12'h023, 12'h063};
    logic [6:0] cfg_mode [8] = '{7'h20, 7'h00, 7'h00, 7'h10, 7'h01, 7'h08, 7'h04, 7'h02};
    logic [1:0] cfg_dma [8] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h3, 2'h0, 2'h0};
    logic [8:0] cfg_tx [8] = '{9'h0a5, 9'h0da, 9'h096, 9'h0c3, 9'h13c, 9'h081, 9'h07e, 9'h0b4};
    logic [7:0] cfg_rx [8] = '{8'ha5, 8'h5a, 8'h96, 8'hc3, 8'h3c, 8'h81, 8'h7e, 8'h6b};
    always #12.5 clk = ~clk;
    always @(posedge clk) tc <= tc + 2'h1;
    serial_async_sync_port #(.BASE_DIV(16'd2)) u_dut (.REF_CLK(clk), .NRST(nrst), .CLK_EN(clk_en),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .SERIAL_IN_PIN(sin), .SERIAL_OUT_PIN(sout),
        .SHIFT_CLOCK_PIN_I(sck_i), .SHIFT_CLOCK_PIN_O(sck_o), .SHIFT_CLOCK_PIN_OE_N(sck_oe_n),
        .TIMER0_UNDERFLOW(tc[1]), .IRQ_RX(irq_rx), .IRQ_TX(irq_tx), .IIO_REQ_RX(iio_rx), .IIO_REQ_TX(iio_tx));
    far_serial_device u_far (.sout(sout), .sclk(sck_o), .oe_n(sck_oe_n), .sin(sin));
    task complete_run;
        if (bad_count == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(negedge clk);
        while (pready !== 1'b1) @(negedge clk);
        rdv = prdata;
        err = pslverr;
        @(posedge clk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rd(input logic [11:0] a);
        apb(1'b0, a, 32'h0);
    endtask
    task wait_done;
        n = 0;
        while (!((irq_rx || iio_rx) && (irq_tx || iio_tx)) && n < 8000)
        begin
            @(posedge clk);
            n++;
        end
        if (n >= 8000)
        begin
            bad_count++;
            complete_run;
        end
    endtask
    initial
    begin
        repeat (60000) @(posedge clk);
        bad_count++;
        complete_run;
    end
    initial
    begin
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        rd(`OFF_CTRL);
        `CHK(rdv[11:0], 12'h023)
        rd(`OFF_MODE);
        `CHK(rdv[6:0], 7'h00)
        rd(12'h01c);
        `CHK({err, rdv}, {1'b1, 32'h0})
        @(posedge clk);
        clk_en <= 1'b0;
        wr(`OFF_CTRL, 32'h0);
        @(posedge clk);
        clk_en <= 1'b1;
        rd(`OFF_CTRL);
        `CHK(rdv[11:0], 12'h023)
        for (int i = 0; i < 8; i++)
        begin
            wr(`OFF_CTRL, {20'h0, cfg_ctrl[i]});
            wr(`OFF_MODE, {25'h0, cfg_mode[i]});
            wr(`OFF_DMAEN, {30'h0, cfg_dma[i]});
            wr(`OFF_MASK, 32'h1f);
            wr(`OFF_TXD, {23'h0, cfg_tx[i]});
            wait_done;
            `CHK({irq_rx, iio_rx}, cfg_dma[i][0] ? 2'b01 : 2'b10)
            rd(`OFF_STAT);
            `CHK(rdv[4:0], 5'h03)
            rd(`OFF_RXD);
            `CHK(rdv[7:0], cfg_rx[i])
            if (i == 7) `CHK(u_far.got, 8'hb4)
            wr(`OFF_STAT, 32'h1f);
            wr(`OFF_DMAEN, 32'h0);
            `CHK({irq_rx, irq_tx}, 2'b00)
        end
        wr(`OFF_MODE, 32'h0);
        wr(`OFF_CTRL, 32'h023);
        wr(`OFF_TXD, 32'h011);
        rdv = 32'h0;
        for (n = 0; n < 400 && rdv[5] !== 1'b1; n++) rd(`OFF_STAT);
        wr(`OFF_TXD, 32'h022);
        rdv = 32'h0;
        for (n = 0; n < 400 && rdv[3] !== 1'b1; n++) rd(`OFF_STAT);
        `CHK(rdv[3:0], 4'hb)
        `CHK(irq_rx, 1'b1)
        wr(`OFF_MASK, 32'h0);
        rd(`OFF_RXD);
        `CHK(rdv[7:0], 8'h11)
        `CHK({irq_rx, irq_tx}, 2'b00)
        complete_run;
    end
endmodule
